//--- host_model.sv
// host model: start pin and the five address pins
// assumes the bench calls its tasks from one process
module host_model (
  input wire logic clk,
  output logic start,
  output logic [4:0] sel
);
  timeunit 1ns;
  timeprecision 1ns;
  initial start = 1'b0;
  initial sel = 5'h00;
  // ==========
  // start request
  // held low long enough for a sample tick to see it
  task automatic start_at(input logic [4:0] a, input int low);
    @(posedge clk);
    start <= 1'b0;
    sel <= a;
    repeat (low) @(posedge clk);
    start <= 1'b1;
  endtask
  task automatic set_sel(input logic [4:0] a);
    @(posedge clk);
    sel <= a;
  endtask
endmodule // host_model

//--- pos_pkg.sv
// positioning start selector: shared constants, types and register map
// assumes one 25 MHz clock and an APB master with 32-bit data
//
// Functional notes
// - store 31 addressable positioning entries
// - start acts on rising edge only
// - start allowed without homing or preset
// - five address bits select entries 1 to 31
// - address zero: error, sequential, homing, immediate
// - immediate target written first, run on start
// - immediate: no chaining, no dwell timer
// - immediate target may change during move
// - decelerate before target, stop there
// - run, stop, cancel, error, free-run abort
// - pause halts, release finishes the move
// - overtravel or limiter may end move early
// - write protect blocks keypad and tool edits
// - edit permit input gates data edits
// - teach input and serial link edit data
// - decimal position change keeps stored digits
// - sample start each 1.0 ms, 0.5 ms processing
// - sequential start runs on to cycle end
package pos_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam real SAMPLE_MS = 1.0;
  localparam real PROC_MS = 0.5;
  localparam int SAMPLE_CYC = int'(SAMPLE_MS * 1.0e-3 * CLK_HZ);
  localparam int PROC_CYC = int'(PROC_MS * 1.0e-3 * CLK_HZ);
  localparam int CNT_W = 16;
  // ==========================================================
  // sizes and entry layout
  localparam int N_ENTRIES = 31;
  localparam int ADDR_W = 5;
  localparam int POS_W = 30;
  localparam int ENT_CONTROL_INPUT_GROUP_BIT = 31;
  localparam int ENT_CYCLE_END_MARK_BIT = 30;
  localparam logic [31:0] ENT_RST = 32'h0;
  localparam logic [POS_W-1:0] DECEL_DIST = 30'h10;
  // ==========================================================
  // register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0c;
  localparam logic [7:0] IMM_OFS = 8'h10;
  localparam logic [7:0] SEL_OFS = 8'h14;
  localparam logic [7:0] DATA_OFS = 8'h18;
  localparam logic [7:0] SHI_OFS = 8'h1c;
  localparam logic [7:0] SLO_OFS = 8'h20;
  localparam logic [7:0] POS_OFS = 8'h24;
  // ==========================================================
  // fields and reset values
  localparam int CTRL_SEQ_LSB = 0;
  localparam int CTRL_WP_BIT = 2;
  localparam int CTRL_EPA_BIT = 3;
  localparam int CTRL_IMMCHG_BIT = 4;
  localparam int CTRL_SOFT_BIT = 5;
  localparam int CTRL_DEC_LSB = 8;
  localparam int CTRL_W = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam int SEL_KEY_BIT = 8;
  localparam logic [POS_W-1:0] SHI_RST = 30'h1fffffff;
  localparam logic [POS_W-1:0] SLO_RST = 30'h20000000;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ADDR = 1;
  localparam int IRQ_ABORT = 2;
  localparam int IRQ_CYCLE_END_MARK = 3;
  localparam int IRQ_EARLY = 4;
  localparam int IRQ_REFUSE = 5;
  localparam int IRQ_W = 6;
  // ==========================================================
  // types
  typedef enum logic [1:0] {SEQ_ERROR, SEQ_SEQUENTIAL, SEQ_HOMING, SEQ_IMMEDIATE} seq_mode_t;
  typedef enum logic [1:0] {K_ENTRY, K_IMM, K_HOME} kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_PROC, ST_MOVE} state_t;
endpackage

//--- pos_store.sv
// positioning entry store: 31 words, one write port, two read ports
// assumes the caller has already checked edit permission
module pos_store
  import pos_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic we,
  input wire logic [ADDR_W-1:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [ADDR_W-1:0] rd_idx_a,
  output logic [31:0] rd_data_a,
  input wire logic [ADDR_W-1:0] rd_idx_b,
  output logic [31:0] rd_data_b
);
  logic [31:0] mem_q [1:N_ENTRIES];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 1; i <= N_ENTRIES; i++) begin
        mem_q[i] <= ENT_RST;
      end
    end else if (ce && we && wr_idx != '0) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  // index zero names no entry and reads as zero
  assign rd_data_a = (rd_idx_a == '0) ? '0 : mem_q[rd_idx_a];
  assign rd_data_b = (rd_idx_b == '0) ? '0 : mem_q[rd_idx_b];
endmodule // pos_store

//--- positioning_start_selector.sv
// positioning start selector: start edge, address decode, motion and stops
// assumes APB master on MCLK; start, address and stop pins are asynchronous
module positioning_start_selector
  import pos_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int PROC_CYCLES = PROC_CYC
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic START,
  input wire logic SEL_BIT0,
  input wire logic SEL_BIT1,
  input wire logic SEL_BIT2,
  input wire logic SEL_BIT3,
  input wire logic SEL_BIT4,
  input wire logic RUN,
  input wire logic FORCED_STOP_IN,
  input wire logic POS_CANCEL,
  input wire logic EXT_OK,
  input wire logic FREE_RUN,
  input wire logic PAUSE,
  input wire logic OVERTRAVEL_LIMIT_POS,
  input wire logic OVERTRAVEL_LIMIT_NEG,
  input wire logic LIMITER,
  input wire logic IMM_CONTINUE,
  input wire logic EDIT_PERMIT,
  input wire logic TEACH,
  output logic BUSY,
  output logic DECEL,
  output logic CYCLE_END_OUT,
  output logic ADDR_ERR,
  output logic [POS_W-1:0] POSITION,
  output logic IRQ
);
  // ==========================================================
  // pin synchronisers (control_input_group and address)
  localparam int I_START = 0;
  localparam int I_SEL = 1;
  localparam int I_RUN = 6;
  localparam int I_FSTOP = 7;
  localparam int I_CANCEL = 8;
  localparam int I_EXTOK = 9;
  localparam int I_FREE = 10;
  localparam int I_PAUSE = 11;
  localparam int I_OTP = 12;
  localparam int I_OTN = 13;
  localparam int I_LIM = 14;
  localparam int I_IMMC = 15;
  localparam int I_PERMIT = 16;
  localparam int I_TEACH = 17;
  localparam int NPIN = 18;
  localparam logic [CNT_W-1:0] SCNT_LAST = CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] PCNT_LAST = CNT_W'(PROC_CYCLES - 1);
  localparam logic [ADDR_W-1:0] LAST_IDX = ADDR_W'(N_ENTRIES);

  logic [NPIN-1:0] pins_in, meta_q, pin_q;
  assign pins_in = {TEACH, EDIT_PERMIT, IMM_CONTINUE, LIMITER, OVERTRAVEL_LIMIT_NEG,
                    OVERTRAVEL_LIMIT_POS, PAUSE, FREE_RUN, EXT_OK, POS_CANCEL,
                    FORCED_STOP_IN, RUN, SEL_BIT4, SEL_BIT3, SEL_BIT2, SEL_BIT1,
                    SEL_BIT0, START};

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      meta_q <= '0;
      pin_q <= '0;
    end else if (CE) begin
      meta_q <= pins_in;
      pin_q <= meta_q;
    end
  end

  // ==========================================================
  // declarations
  state_t state_q;
  kind_t kind_q;
  seq_mode_t seq_mode;
  logic [ADDR_W-1:0] addr_s, idx_q;
  logic [CNT_W-1:0] smp_cnt_q, proc_cnt_q;
  logic start_smp_q, teach_prev_q, smp_tick, start_edge, go, go_err;
  logic abort_c, pause_c, early_c, soft_ot, step_up, at_tgt, proc_done;
  logic chain, imm_again, cycle_end_mark, mv, done_ev;
  logic signed [POS_W-1:0] pos_q, target_q, imm_q, shi_q, slo_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [IRQ_W-1:0] irq_stat_q, mask_q, ev;
  logic [8:0] sel_q;
  logic [31:0] ent, sel_rd, st_wdata, prdata_q;
  logic apb_acc, apb_wr, data_wr, teach_edge, st_we, ok_apb, ok_teach, imm_upd;
  logic pready_q, pslverr_q, busy_q, decel_q, cyc_end_q, addr_err_q, irq_q;

  function automatic logic [POS_W-1:0] dist_f(input logic signed [POS_W-1:0] a,
                                               input logic signed [POS_W-1:0] b);
    dist_f = (a > b) ? POS_W'(a - b) : POS_W'(b - a);
  endfunction

  // edits need a real entry, the permit input when assigned, and
  // no write protection for keypad or tool sourced edits
  function automatic logic edit_ok_f(input logic [ADDR_W-1:0] idx, input logic key,
                                     input logic [CTRL_W-1:0] ctrl, input logic permit);
    edit_ok_f = (idx != '0) && (!ctrl[CTRL_EPA_BIT] || permit) && !(key && ctrl[CTRL_WP_BIT]);
  endfunction

  // ==========================================================
  // start sampling every sample period
  assign addr_s = pin_q[I_SEL +: ADDR_W];
  assign seq_mode = seq_mode_t'(ctrl_q[CTRL_SEQ_LSB +: 2]);
  assign smp_tick = (smp_cnt_q == SCNT_LAST);
  assign start_edge = smp_tick && pin_q[I_START] && !start_smp_q;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      smp_cnt_q <= '0;
      start_smp_q <= 1'b0;
    end else if (CE) begin
      smp_cnt_q <= smp_tick ? '0 : smp_cnt_q + CNT_W'(1);
      if (smp_tick) begin
        start_smp_q <= pin_q[I_START];
      end
    end
  end

  // ==========================================================
  // stop and motion conditions
  assign abort_c = !pin_q[I_RUN] || !pin_q[I_FSTOP] || pin_q[I_CANCEL]
                   || !pin_q[I_EXTOK] || pin_q[I_FREE];
  assign pause_c = pin_q[I_PAUSE];
  assign step_up = target_q > pos_q;
  assign soft_ot = ctrl_q[CTRL_SOFT_BIT] && (step_up ? pos_q >= shi_q : pos_q <= slo_q);
  assign early_c = (step_up ? pin_q[I_OTP] : pin_q[I_OTN]) || pin_q[I_LIM] || soft_ot;
  assign at_tgt = (pos_q == target_q);
  assign proc_done = (proc_cnt_q == PCNT_LAST);
  assign cycle_end_mark = ent[ENT_CYCLE_END_MARK_BIT];
  // continuation only for stored entries; immediate data never chains by itself
  assign chain = (kind_q == K_ENTRY) && !cycle_end_mark && (idx_q != LAST_IDX)
                 && (ent[ENT_CONTROL_INPUT_GROUP_BIT] || (seq_mode == SEQ_SEQUENTIAL && addr_s == '0));
  assign imm_again = (kind_q == K_IMM) && pin_q[I_IMMC];
  // no homing or preset state gates the start
  assign go = CE && state_q == ST_IDLE && start_edge && !abort_c;
  assign go_err = (addr_s == '0) && (seq_mode == SEQ_ERROR || (seq_mode == SEQ_SEQUENTIAL
                  && (idx_q == '0 || idx_q == LAST_IDX)));
  assign mv = CE && state_q == ST_MOVE;
  assign done_ev = mv && !abort_c && !pause_c && at_tgt;

  // ==========================================================
  // sequencer
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ST_IDLE;
      idx_q <= '0;
      kind_q <= K_ENTRY;
    end else if (CE) begin
      case (state_q)
        ST_IDLE: begin
          if (go && !go_err) begin
            state_q <= ST_PROC;
            if (addr_s != '0) begin
              idx_q <= addr_s;
              kind_q <= K_ENTRY;
            end else begin
              case (seq_mode)
                SEQ_SEQUENTIAL: begin
                  idx_q <= idx_q + ADDR_W'(1);
                  kind_q <= K_ENTRY;
                end
                SEQ_HOMING: kind_q <= K_HOME;
                default: kind_q <= K_IMM;
              endcase
            end
          end
        end
        ST_PROC: begin
          if (abort_c) begin
            state_q <= ST_IDLE;
          end else if (proc_done) begin
            state_q <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (abort_c) begin
            state_q <= ST_IDLE;
          end else if (pause_c) begin
            state_q <= ST_MOVE;
          end else if (at_tgt) begin
            if (chain) begin
              idx_q <= idx_q + ADDR_W'(1);
              state_q <= ST_PROC;
            end else if (imm_again) begin
              state_q <= ST_PROC;
            end else begin
              state_q <= ST_IDLE;
            end
          end else if (early_c) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      proc_cnt_q <= '0;
    end else if (CE) begin
      proc_cnt_q <= (state_q == ST_PROC) ? proc_cnt_q + CNT_W'(1) : '0;
    end
  end

  // ==========================================================
  // target and position; one unit per clock stands in for the profile
  assign imm_upd = apb_wr && PADDR == IMM_OFS && ctrl_q[CTRL_IMMCHG_BIT]
                   && state_q == ST_MOVE && kind_q == K_IMM;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      target_q <= '0;
      pos_q <= '0;
    end else if (CE) begin
      if (state_q == ST_PROC && proc_done) begin
        target_q <= (kind_q == K_HOME) ? '0 : (kind_q == K_IMM) ? imm_q : ent[POS_W-1:0];
      end else if (imm_upd) begin
        target_q <= PWDATA[POS_W-1:0];
      end
      if (mv && !abort_c && !pause_c && !at_tgt && !early_c) begin
        pos_q <= step_up ? pos_q + POS_W'(1) : pos_q - POS_W'(1);
      end
    end
  end

  // ==========================================================
  // entry store and edit paths
  assign data_wr = apb_wr && PADDR == DATA_OFS;
  assign teach_edge = CE && pin_q[I_TEACH] && !teach_prev_q;
  assign ok_apb = edit_ok_f(sel_q[ADDR_W-1:0], sel_q[SEL_KEY_BIT], ctrl_q, pin_q[I_PERMIT]);
  assign ok_teach = edit_ok_f(sel_q[ADDR_W-1:0], 1'b0, ctrl_q, pin_q[I_PERMIT]);
  // a teach edge colliding with a bus write to the data register is refused, not queued
  assign st_we = (data_wr && ok_apb) || (!data_wr && teach_edge && ok_teach);
  assign st_wdata = data_wr ? PWDATA : {sel_rd[31:POS_W], pos_q};

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      teach_prev_q <= 1'b0;
    end else if (CE) begin
      teach_prev_q <= pin_q[I_TEACH];
    end
  end

  pos_store u_store (
    .clk(MCLK),
    .arst_n(ARST_N),
    .ce(CE),
    .we(st_we),
    .wr_idx(sel_q[ADDR_W-1:0]),
    .wr_data(st_wdata),
    .rd_idx_a(idx_q),
    .rd_data_a(ent),
    .rd_idx_b(sel_q[ADDR_W-1:0]),
    .rd_data_b(sel_rd)
  );

  // ==========================================================
  // APB slave: one wait state, writes land on the completing edge
  assign apb_acc = CE && PSEL && PENABLE;
  assign apb_wr = apb_acc && pready_q && PWRITE;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (CE) begin
      pready_q <= apb_acc && !pready_q;
      pslverr_q <= apb_acc && !pready_q && PADDR > POS_OFS;
      if (apb_acc && !pready_q) begin
        case (PADDR)
          CTRL_OFS: prdata_q <= 32'(ctrl_q);
          STAT_OFS: prdata_q <= 32'({kind_q, idx_q, addr_err_q, pause_c, state_q});
          IRQ_OFS: prdata_q <= 32'(irq_stat_q);
          MASK_OFS: prdata_q <= 32'(mask_q);
          IMM_OFS: prdata_q <= 32'(unsigned'(imm_q));
          SEL_OFS: prdata_q <= 32'(sel_q);
          DATA_OFS: prdata_q <= sel_rd;
          SHI_OFS: prdata_q <= 32'(unsigned'(shi_q));
          SLO_OFS: prdata_q <= 32'(unsigned'(slo_q));
          POS_OFS: prdata_q <= 32'(unsigned'(pos_q));
          default: prdata_q <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= CTRL_RST;
      mask_q <= '0;
      imm_q <= '0;
      sel_q <= '0;
      shi_q <= SHI_RST;
      slo_q <= SLO_RST;
    end else if (apb_wr) begin
      case (PADDR)
        // decimal position is only stored; entry words are never rescaled
        CTRL_OFS: ctrl_q <= PWDATA[CTRL_W-1:0];
        MASK_OFS: mask_q <= PWDATA[IRQ_W-1:0];
        IMM_OFS: imm_q <= PWDATA[POS_W-1:0];
        SEL_OFS: sel_q <= PWDATA[8:0];
        SHI_OFS: shi_q <= PWDATA[POS_W-1:0];
        SLO_OFS: slo_q <= PWDATA[POS_W-1:0];
        default: sel_q <= sel_q;
      endcase
    end
  end

  // ==========================================================
  // events, sticky status, interrupt; a set beats a same-cycle clear
  always_comb begin
    ev = '0;
    ev[IRQ_DONE] = done_ev;
    ev[IRQ_ADDR] = go && go_err;
    ev[IRQ_ABORT] = mv && abort_c;
    ev[IRQ_CYCLE_END_MARK] = done_ev && kind_q == K_ENTRY && cycle_end_mark;
    ev[IRQ_EARLY] = mv && !abort_c && !pause_c && !at_tgt && early_c;
    ev[IRQ_REFUSE] = (data_wr && !ok_apb) || (teach_edge && (data_wr || !ok_teach));
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else if (CE) begin
      irq_stat_q <= (irq_stat_q & ~((apb_wr && PADDR == IRQ_OFS) ? PWDATA[IRQ_W-1:0] : '0)) | ev;
      irq_q <= |(irq_stat_q & mask_q);
    end
  end

  // ==========================================================
  // pin outputs, all registered
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      busy_q <= 1'b0;
      decel_q <= 1'b0;
      cyc_end_q <= 1'b0;
      addr_err_q <= 1'b0;
    end else if (CE) begin
      busy_q <= (state_q != ST_IDLE);
      decel_q <= (state_q == ST_MOVE) && (dist_f(target_q, pos_q) <= DECEL_DIST);
      if (go) begin
        addr_err_q <= go_err;
        cyc_end_q <= 1'b0;
      end else if (ev[IRQ_CYCLE_END_MARK]) begin
        cyc_end_q <= 1'b1;
      end
    end
  end

  assign BUSY = busy_q;
  assign DECEL = decel_q;
  assign CYCLE_END_OUT = cyc_end_q;
  assign ADDR_ERR = addr_err_q;
  assign POSITION = pos_q;
  assign IRQ = irq_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  sequence s_enter;
    (state_q == ST_IDLE) ##1 (state_q == ST_PROC);
  endsequence

  start_edge_a: assert property (
    s_enter |-> !$past(start_smp_q) && start_smp_q)
    else $error("move began without a start rising edge");
  addr_latch_a: assert property (
    s_enter |-> ($past(addr_s) == '0 || idx_q == $past(addr_s)))
    else $error("entry index differs from address at start");
  addr_err_a: assert property (
    (go && addr_s == '0 && seq_mode == SEQ_ERROR) |=> addr_err_q && state_q == ST_IDLE)
    else $error("address zero in error mode did not flag");
  proc_len_a: assert property (
    (state_q == ST_MOVE && $past(state_q) == ST_PROC) |-> $past(proc_cnt_q) == PCNT_LAST)
    else $error("start processing time wrong");
  decel_flag_a: assert property (
    (CE && state_q == ST_MOVE && dist_f(target_q, pos_q) <= DECEL_DIST) |=> decel_q)
    else $error("deceleration flag missing near target");
  abort_stop_a: assert property (
    (CE && state_q == ST_MOVE && abort_c) |=> state_q == ST_IDLE && irq_stat_q[IRQ_ABORT])
    else $error("abort input did not stop the move");
  pause_hold_a: assert property (
    (CE && state_q == ST_MOVE && pause_c && !abort_c) |=> state_q == ST_MOVE && $stable(pos_q))
    else $error("pause did not hold the move");
  early_end_a: assert property (
    (ev[IRQ_EARLY]) |=> state_q == ST_IDLE && irq_stat_q[IRQ_EARLY])
    else $error("overtravel or limiter did not end the move");
  protect_a: assert property (
    (data_wr && sel_q[SEL_KEY_BIT] && ctrl_q[CTRL_WP_BIT]) |-> !st_we ##1 irq_stat_q[IRQ_REFUSE])
    else $error("protected keypad edit was stored");
  imm_change_a: assert property (
    imm_upd |=> target_q == $past(PWDATA[POS_W-1:0]))
    else $error("immediate change not taken during move");
endmodule // positioning_start_selector

//--- testbench.sv
// bench: apb master, host model, queued read checks
// assumes short sample and processing counts
module testbench;
  import pos_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 8;
  localparam int PC = 4;
  localparam logic [31:0] PM = 32'h3fffffff;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pause = 1'b0, permit = 1'b0;
  logic ce = 1'b1, imc = 1'b0, teach = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic rdy, serr, start, busy, cycle_end_mark, aerr, irq, decel;
  logic [29:0] pos;
  logic [4:0] sel;
  logic [4:0] abt = 5'h00;
  logic [2:0] ev = 3'h0;
  logic [4:0] a;
  logic [31:0] t;
  int failures = 0;
  int checks_done = 0;
  int lat;
  int dec_n = 0;
  logic [64:0] expq[$];
  always #20 clk = ~clk;
  positioning_start_selector #(.SAMPLE_CYCLES(SC), .PROC_CYCLES(PC)) i_dut (
    .MCLK(clk), .ARST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy),
    .PSLVERR(serr), .START(start), .SEL_BIT0(sel[0]), .SEL_BIT1(sel[1]),
    .SEL_BIT2(sel[2]), .SEL_BIT3(sel[3]), .SEL_BIT4(sel[4]), .RUN(~abt[0]),
    .FORCED_STOP_IN(~abt[1]), .EXT_OK(~abt[2]), .POS_CANCEL(abt[3]),
    .FREE_RUN(abt[4]), .PAUSE(pause), .OVERTRAVEL_LIMIT_POS(ev[0]),
    .OVERTRAVEL_LIMIT_NEG(ev[2]), .LIMITER(ev[1]), .IMM_CONTINUE(imc),
    .EDIT_PERMIT(permit), .TEACH(teach), .BUSY(busy), .DECEL(decel),
    .CYCLE_END_OUT(cycle_end_mark), .ADDR_ERR(aerr), .POSITION(pos), .IRQ(irq));
  host_model i_host (.clk(clk), .start(start), .sel(sel));
  // ==========
  // checking and closing
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic give_up();
    failures++;
    tally_and_finish();
  endtask
  // ==========
  // apb master; a read notes its expected word, mask and error flag
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     input logic [31:0] m = 32'hffffffff, input logic e = 1'b0);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= ad;
    pwd <= d;
    if (!w)
      expq.push_back({e, m, d});
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 50 && rdy !== 1'b1; n++)
      @(posedge clk);
    if (n == 50)
      give_up();
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  always @(posedge clk) begin : watch
    logic [64:0] e;
    if (decel === 1'b1)
      dec_n++;
    if (psel && pen && rdy === 1'b1 && !pwr) begin
      e = expq.pop_front();
      chk({serr, prd & e[63:32]}, {e[64], e[31:0]});
    end
  end
  // bounded wait for the busy level, cycles counted in lat
  task automatic wait_busy(input logic v);
    for (lat = 0; lat < 4000 && busy !== v; lat++)
      @(posedge clk);
    if (lat == 4000)
      give_up();
  endtask
  task automatic launch(input logic [4:0] ad);
    i_host.start_at(ad, 3 * SC);
    wait_busy(1'b1);
    chk(lat <= SC + 6, 1'b1);
  endtask
  task automatic ent(input logic [31:0] i, input logic [31:0] d);
    apb(1, SEL_OFS, i);
    apb(1, DATA_OFS, d);
  endtask
  // ==========
  // scenarios
  initial begin
    void'($urandom(32'hb1fd));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, CTRL_OFS, 32'h0);
    apb(0, SHI_OFS, {2'b0, SHI_RST});
    apb(0, SLO_OFS, {2'b0, SLO_RST});
    apb(0, MASK_OFS, 32'h0);
    apb(0, 8'h40, 32'h0, 32'hffffffff, 1'b1);
    apb(1, STAT_OFS, 32'hffffffff);
    apb(0, STAT_OFS, 32'h0, 32'h3);
    apb(1, MASK_OFS, 32'h3f);
    a = 5'(1 + $urandom % 31);
    t = 32'h14 + $urandom % 40;
    ent({27'h0, a}, t);
    apb(0, DATA_OFS, t);
    launch(a);
    wait_busy(1'b0);
    chk(pos, t);
    chk(dec_n, DECEL_DIST + 1);
    apb(0, POS_OFS, t, PM);
    apb(0, IRQ_OFS, 32'h1, 32'h1);
    repeat (4 * SC) @(posedge clk);
    chk(busy, 1'b0);
    // address zero under the error, homing and immediate settings
    apb(1, CTRL_OFS, 32'h0);
    i_host.start_at(5'h00, 3 * SC);
    repeat (SC + 8) @(posedge clk);
    chk(aerr, 1'b1);
    apb(0, IRQ_OFS, 32'h2, 32'h2);
    apb(1, CTRL_OFS, 32'h2);
    launch(5'h00);
    wait_busy(1'b0);
    chk(aerr, 1'b0);
    chk(pos, 30'h0);
    apb(1, IMM_OFS, 32'h258);
    apb(1, CTRL_OFS, 32'h13);
    launch(5'h00);
    apb(1, IMM_OFS, 32'hc8);
    wait_busy(1'b0);
    apb(0, POS_OFS, 32'hc8, PM);
    // continue input keeps rerunning the immediate target until dropped
    imc <= 1'b1;
    launch(5'h00);
    apb(1, IMM_OFS, 32'h12c);
    imc <= 1'b0;
    wait_busy(1'b0);
    apb(0, POS_OFS, 32'h12c, PM);
    ent(32'h5, 32'hfa);
    ent(32'h6, 32'h4000012c);
    apb(1, CTRL_OFS, 32'h1);
    launch(5'h05);
    i_host.set_sel(5'h00);
    wait_busy(1'b0);
    apb(0, POS_OFS, 32'h12c, PM);
    chk(cycle_end_mark, 1'b1);
    // every abort input, then the three pin early-stop causes, mid-move
    apb(1, CTRL_OFS, 32'h0);
    for (int k = 0; k < 8; k++) begin
      ent(32'h7, (k[0] && k != 5) ? 32'h64 : 32'h1f4);
      launch(5'h07);
      repeat (PC + 8) @(posedge clk);
      if (k < 5)
        abt[k] <= 1'b1;
      else
        ev[k - 5] <= 1'b1;
      wait_busy(1'b0);
      abt <= 5'h00;
      ev <= 3'h0;
      apb(0, IRQ_OFS, (k < 5) ? 32'h4 : 32'h10, 32'h14);
      apb(1, IRQ_OFS, 32'h3f);
    end
    ent(32'h8, 32'h3e8);
    launch(5'h08);
    repeat (PC + 8) @(posedge clk);
    // clock enable low must freeze the move mid-flight
    ce <= 1'b0;
    @(posedge clk);
    t = pos;
    repeat (20) @(posedge clk);
    chk(pos, t);
    ce <= 1'b1;
    pause <= 1'b1;
    repeat (800) @(posedge clk);
    chk(busy, 1'b1);
    pause <= 1'b0;
    wait_busy(1'b0);
    apb(0, POS_OFS, 32'h3e8, PM);
    // edit refusal, interrupt raise, clear and mask
    apb(1, IRQ_OFS, 32'h3f);
    apb(1, CTRL_OFS, 32'h4);
    ent(32'h109, 32'h4d);
    apb(0, DATA_OFS, 32'h0);
    apb(0, IRQ_OFS, 32'h20, 32'h20);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    apb(1, IRQ_OFS, 32'h3f);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    apb(1, MASK_OFS, 32'h0);
    apb(1, CTRL_OFS, 32'h8);
    ent(32'ha, 32'h37);
    apb(0, DATA_OFS, 32'h0);
    chk(irq, 1'b0);
    permit <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1, DATA_OFS, 32'h37);
    apb(0, DATA_OFS, 32'h37);
    apb(1, CTRL_OFS, 32'h508);
    apb(0, CTRL_OFS, 32'h508);
    apb(0, DATA_OFS, 32'h37);
    // teach stores the current position into the selected entry
    teach <= 1'b1;
    repeat (4) @(posedge clk);
    teach <= 1'b0;
    apb(0, DATA_OFS, 32'h3e8);
    tally_and_finish();
  end
endmodule // testbench
